// >>> inc/eic_pkg.sv
// Package with register map, field layout and constants of the interrupt block.
package eic_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          NUM_PINS        = 32;
  localparam int          SYNC_CYCLES     = 3;
  localparam logic [7:0]  OFF_CONTROL_A   = 8'h00;
  localparam logic [7:0]  OFF_SYNC_BUSY   = 8'h04;
  localparam logic [7:0]  OFF_IRQ_CLEAR   = 8'h0C;
  localparam logic [7:0]  OFF_IRQ_SET     = 8'h10;
  localparam logic [7:0]  OFF_IRQ_FLAG    = 8'h14;
  localparam logic [7:0]  OFF_DEB_EN      = 8'h30;
  localparam logic [7:0]  OFF_DEB_PRESC   = 8'h34;
  localparam logic [7:0]  OFF_PIN_STATE   = 8'h38;
  localparam int          BIT_SOFTWARE_RESET_BIT       = 0;
  localparam int          BIT_ENABLE      = 1;
  localparam int          BIT_CLOCK_SOURCE_SELECT       = 4;
  localparam logic [7:0]  CONTROL_A_RST   = 8'h00;
  localparam logic [31:0] DEB_PRESC_MASK  = 32'h0001FFFF;
  localparam logic [31:0] WORD_ZERO       = 32'h00000000;
  localparam logic [31:0] BUSY_MASK       = 32'h00000003;
endpackage

// >>> design/eic_regs.sv
// External interrupt controller register interface on Avalon-MM.
`timescale 1ns/10ps
module eic_regs #(
  parameter int SYNC_CYCLES = eic_pkg::SYNC_CYCLES
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Avalon-MM slave.
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // External pins.
  input  wire logic [31:0] pin_i,
  // Controller outputs.
  output logic             irq_o,
  output logic             ctrl_enable_o,
  output logic             clock_source_select_o,
  output logic [31:0]      debounce_enable_o,
  output logic [31:0]      debounce_prescaler_o
);

  logic [7:0]  control_a_r;
  logic [31:0] irq_en_r;
  logic [31:0] flag_r;
  logic [31:0] deb_en_r;
  logic [31:0] deb_presc_r;
  logic [31:0] pin_d_r;
  logic [31:0] pin_state_r;
  logic [31:0] rdata_r;
  logic [2:0]  busy_cnt_r;
  logic        rd_done_r;
  logic        wr_en;
  logic        rd_en;
  logic        software_reset_bit_req;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] rd_nxt;
  logic [31:0] rise;

  // Expands byte enables to a bit mask so any lane mix is served alone.
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Writes take effect at once; reads wait one cycle for registered data.
  assign wmask = lane_mask(avs_byteenable_i);
  assign wval  = avs_writedata_i & wmask;
  assign wr_en = avs_write_i;
  assign rd_en = avs_read_i & ~rd_done_r;
  assign avs_waitrequest_o = avs_read_i & ~rd_done_r;
  assign software_reset_bit_req = wr_en && avs_address_i == eic_pkg::OFF_CONTROL_A &&
                     wval[eic_pkg::BIT_SOFTWARE_RESET_BIT];

  // Read handshake: answer lands one cycle after the request is seen.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_done_r <= 1'b0;
    end else begin
      rd_done_r <= rd_en;
    end
  end

  // Control register; reset bit self-clears and reads zero.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      control_a_r <= eic_pkg::CONTROL_A_RST;
    end else if (software_reset_bit_req) begin
      control_a_r <= eic_pkg::CONTROL_A_RST;
    end else if (wr_en && avs_address_i == eic_pkg::OFF_CONTROL_A &&
                 avs_byteenable_i[0]) begin
      control_a_r[eic_pkg::BIT_ENABLE] <= wval[eic_pkg::BIT_ENABLE];
      control_a_r[eic_pkg::BIT_CLOCK_SOURCE_SELECT]  <= wval[eic_pkg::BIT_CLOCK_SOURCE_SELECT];
    end
  end

  // Busy counter models the crossing delay of the software reset and the enable bit; the clock
  // select write is direct and so never starts it.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_cnt_r <= 3'h0;
    end else if (software_reset_bit_req || (wr_en &&
                 avs_address_i == eic_pkg::OFF_CONTROL_A &&
                 avs_byteenable_i[0] &&
                 wval[eic_pkg::BIT_ENABLE] !=
                 control_a_r[eic_pkg::BIT_ENABLE])) begin
      busy_cnt_r <= 3'(SYNC_CYCLES);
    end else if (busy_cnt_r != 3'h0) begin
      busy_cnt_r <= busy_cnt_r - 3'h1;
    end
  end

  // One shared enable state behind both set and clear addresses.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_en_r <= eic_pkg::WORD_ZERO;
    end else if (software_reset_bit_req) begin
      irq_en_r <= eic_pkg::WORD_ZERO;
    end else if (wr_en && avs_address_i == eic_pkg::OFF_IRQ_SET) begin
      irq_en_r <= irq_en_r | wval;
    end else if (wr_en && avs_address_i == eic_pkg::OFF_IRQ_CLEAR) begin
      irq_en_r <= irq_en_r & ~wval;
    end
  end

  // Enable-protected debounce configuration.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      deb_en_r    <= eic_pkg::WORD_ZERO;
      deb_presc_r <= eic_pkg::WORD_ZERO;
    end else if (software_reset_bit_req) begin
      deb_en_r    <= eic_pkg::WORD_ZERO;
      deb_presc_r <= eic_pkg::WORD_ZERO;
    end else if (wr_en && !control_a_r[eic_pkg::BIT_ENABLE]) begin
      if (avs_address_i == eic_pkg::OFF_DEB_EN) begin
        deb_en_r <= (deb_en_r & ~wmask) | wval;
      end
      if (avs_address_i == eic_pkg::OFF_DEB_PRESC) begin
        deb_presc_r <= ((deb_presc_r & ~wmask) | wval) &
                       eic_pkg::DEB_PRESC_MASK;
      end
    end
  end

  // Pin sampling and rising-edge flags; a new edge beats a same-cycle clear.
  assign rise = pin_i & ~pin_d_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_d_r     <= eic_pkg::WORD_ZERO;
      pin_state_r <= eic_pkg::WORD_ZERO;
      flag_r      <= eic_pkg::WORD_ZERO;
    end else begin
      pin_d_r     <= pin_i;
      pin_state_r <= pin_i;
      if (software_reset_bit_req) begin
        flag_r <= eic_pkg::WORD_ZERO;
      end else if (wr_en && avs_address_i == eic_pkg::OFF_IRQ_FLAG) begin
        flag_r <= (flag_r & ~wval) |
                  (rise & {32{control_a_r[eic_pkg::BIT_ENABLE]}});
      end else begin
        flag_r <= flag_r |
                  (rise & {32{control_a_r[eic_pkg::BIT_ENABLE]}});
      end
    end
  end

  // Read mux; unmapped offsets read zero.
  always_comb begin
    rd_nxt = eic_pkg::WORD_ZERO;
    case (avs_address_i)
      eic_pkg::OFF_CONTROL_A: begin
        rd_nxt = {24'h000000, control_a_r & 8'hFE};
      end
      eic_pkg::OFF_SYNC_BUSY: begin
        rd_nxt = (busy_cnt_r != 3'h0) ? eic_pkg::BUSY_MASK
                                      : eic_pkg::WORD_ZERO;
      end
      eic_pkg::OFF_IRQ_CLEAR: rd_nxt = irq_en_r;
      eic_pkg::OFF_IRQ_SET:   rd_nxt = irq_en_r;
      eic_pkg::OFF_IRQ_FLAG:  rd_nxt = flag_r;
      eic_pkg::OFF_DEB_EN:    rd_nxt = deb_en_r;
      eic_pkg::OFF_DEB_PRESC: rd_nxt = deb_presc_r;
      eic_pkg::OFF_PIN_STATE: rd_nxt = pin_state_r;
      default:                rd_nxt = eic_pkg::WORD_ZERO;
    endcase
  end

  // Read data captured whole so a wide read is atomic.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= eic_pkg::WORD_ZERO;
    end else if (rd_en) begin
      rdata_r <= rd_nxt & lane_mask(avs_byteenable_i);
    end
  end

  // Outputs.
  assign avs_readdata_o        = rdata_r;
  assign irq_o                 = |(flag_r & irq_en_r);
  assign ctrl_enable_o         = control_a_r[eic_pkg::BIT_ENABLE];
  assign clock_source_select_o = control_a_r[eic_pkg::BIT_CLOCK_SOURCE_SELECT];
  assign debounce_enable_o     = deb_en_r;
  assign debounce_prescaler_o  = deb_presc_r;

endmodule

// >>> dv/eic_regs_chk.sv
// Assertion checker for the interrupt register block.
`timescale 1ns/10ps
module eic_regs_chk #(parameter int SYNC_CYCLES = 3) (
  // Clock, reset and bus; grouped to keep the file short.
  input wire logic        clk_i, resetn_i, avs_read_i, avs_write_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic [31:0] avs_writedata_i, avs_readdata_o,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic        avs_waitrequest_o, irq_o,
  input wire logic        ctrl_enable_o, clock_source_select_o,
  // Pins and debounce outputs.
  input wire logic [31:0] pin_i, debounce_enable_o, debounce_prescaler_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Lane mask and the merge a partial write should leave behind.
  wire logic [31:0] lane = {{8{avs_byteenable_i[3]}},
    {8{avs_byteenable_i[2]}}, {8{avs_byteenable_i[1]}},
    {8{avs_byteenable_i[0]}}};
  wire logic [31:0] mrg = (avs_writedata_i & lane) |
    (debounce_enable_o & ~lane);
  wire logic ctl_wr = avs_write_i && avs_address_i == 8'h00 &&
    avs_byteenable_i[0];
  wire logic deb_wr = avs_write_i && avs_address_i == 8'h30;
  wr_nowait_a: assert property (avs_write_i |-> !avs_waitrequest_o)
    else $error("write stalled");
  rd_answer_a: assert property (avs_read_i && avs_waitrequest_o |=>
    !avs_waitrequest_o) else $error("read not answered");
  rd_lanes_a: assert property (avs_read_i && !avs_waitrequest_o |->
    (avs_readdata_o & ~lane) == 32'h0) else $error("lane leak");
  ctl_enable_a: assert property (ctl_wr && avs_writedata_i[1] &&
    !avs_writedata_i[0] |-> ##[1:4] ctrl_enable_o) else $error("no enable");
  clk_select_a: assert property (ctl_wr && !avs_writedata_i[0] |=>
    clock_source_select_o == $past(avs_writedata_i[4]))
    else $error("clock select wrong");
  soft_reset_a: assert property (ctl_wr && avs_writedata_i[0] |=>
    !ctrl_enable_o && !clock_source_select_o && debounce_enable_o == 0)
    else $error("reset incomplete");
  deb_lock_a: assert property (deb_wr && ctrl_enable_o |=>
    $stable(debounce_enable_o)) else $error("protected write took");
  deb_merge_a: assert property (deb_wr && !ctrl_enable_o |=>
    debounce_enable_o == $past(mrg)) else $error("lane merge wrong");
  cover property ($rose(irq_o));
  cover property (deb_wr && ctrl_enable_o);
  cover property (avs_read_i && !avs_waitrequest_o && !avs_byteenable_i[0]);
endmodule
bind eic_regs eic_regs_chk #(.SYNC_CYCLES(SYNC_CYCLES)) i_eic_regs_chk (.*);

// >>> dv/eic_pin_model.sv
// Model of the off-chip sources that drive the interrupt pins.
`timescale 1ns/10ps
module eic_pin_model #(parameter int LAG = 2) (
  input  wire logic        clk_i,
  input  wire logic [31:0] level_i,
  output logic      [31:0] pin_o
);
  // Sources settle LAG cycles late, so a slow edge is exercised.
  logic [31:0] pipe_r [LAG];
  always_ff @(posedge clk_i) begin
    pipe_r[0] <= level_i;
    for (int k = 1; k < LAG; k++) pipe_r[k] <= pipe_r[k-1];
  end
  assign pin_o = pipe_r[LAG-1];
endmodule

// >>> dv/tb_eic_regs.sv
// Self-checking bench for the interrupt register block.
`timescale 1ns/10ps
module tb_eic_regs;
  logic        clk_i = 0, resetn_i = 0, rd = 0, wr = 0, wt, irq;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  be = 4'hF;
  logic [31:0] wd = 32'h0, lvl = 32'h0, rdat, pins, w, c, d, q [$];
  int          error_cnt = 0, cmp_count = 0;
  always #5 clk_i = ~clk_i;
  eic_pin_model i_eic_pin_model (.clk_i(clk_i), .level_i(lvl), .pin_o(pins));
  eic_regs i_eic_regs (.clk_i(clk_i), .resetn_i(resetn_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .pin_i(pins), .irq_o(irq), .ctrl_enable_o(),
    .clock_source_select_o(), .debounce_enable_o(),
    .debounce_prescaler_o());
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (e !== g) begin
      $display("mismatch %s exp %h got %h", n, e, g);
      error_cnt++;
    end
  endtask
  // Held until waitrequest is seen low; a read notes its expectation.
  task automatic bus(logic r, logic [7:0] a, logic [31:0] v, logic [3:0] b);
    int n;
    n = 0;
    if (r) q.push_back(v);
    @(posedge clk_i);
    adr <= a;
    wd <= r ? 32'h0 : v;
    be <= b;
    rd <= r;
    wr <= !r;
    do begin @(posedge clk_i); n++; end while (wt !== 1'b0 && n < 50);
    if (n >= 50) error_cnt++;
    rd <= 0;
    wr <= 0;
  endtask
  task automatic irq_is(logic e);
    int n;
    n = 0;
    while (irq !== e && n < 16) begin @(posedge clk_i); n++; end
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task automatic results();
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Read data are compared at the edge where the answer stands.
  always @(posedge clk_i)
    if (rd && wt === 1'b0) chk("readdata", q.pop_front(), rdat);
  initial begin #200us; error_cnt++; results(); end
  initial begin
    w = $urandom(32'h107b42a0);
    repeat (5) @(posedge clk_i);
    resetn_i <= 1;
    w = $urandom;
    c = $urandom;
    d = $urandom;
    bus(1, 8'h00, 32'h0, 4'hF);
    bus(1, 8'h10, 32'h0, 4'hF);
    bus(0, 8'h10, w, 4'hF);
    bus(1, 8'h0C, w, 4'hF);
    bus(0, 8'h0C, c, 4'hF);
    bus(1, 8'h10, w & ~c, 4'hF);
    bus(0, 8'h30, d, 4'h4);
    bus(1, 8'h30, {8'h00, d[23:16], 16'h0}, 4'hC);
    bus(0, 8'h34, 32'hFFFFFFFF, 4'hF);
    bus(1, 8'h34, eic_pkg::DEB_PRESC_MASK, 4'hF);
    bus(0, 8'h00, 32'h10, 4'h1);
    bus(1, 8'h04, 32'h0, 4'hF);
    bus(1, 8'h00, 32'h10, 4'hF);
    bus(0, 8'h00, 32'h02, 4'h1);
    bus(1, 8'h04, eic_pkg::BUSY_MASK, 4'hF);
    repeat (eic_pkg::SYNC_CYCLES + 2) @(posedge clk_i);
    bus(1, 8'h04, 32'h0, 4'hF);
    bus(0, 8'h30, ~d, 4'hF);
    bus(1, 8'h30, {8'h00, d[23:16], 16'h0}, 4'hF);
    bus(1, 8'h00, 32'h02, 4'hF);
    bus(0, 8'h10, 32'h8, 4'hF);
    lvl <= 32'h8;
    irq_is(1);
    bus(0, 8'h0C, 32'h8, 4'h1);
    irq_is(0);
    bus(0, 8'h10, 32'h8, 4'h1);
    irq_is(1);
    bus(0, 8'h14, 32'h8, 4'h1);
    irq_is(0);
    bus(1, 8'h20, 32'h0, 4'hF);
    bus(0, 8'h00, 32'h01, 4'h1);
    bus(1, 8'h10, 32'h0, 4'hF);
    @(posedge clk_i);
    results();
  end
endmodule
